//--- bssp_pkg.sv
package bssp_pkg;
    // boot source encodings
    typedef enum logic [1:0] {
        BSSP_BOOT_NAND  = 2'h0,
        BSSP_BOOT_FLASH = 2'h1,
        BSSP_BOOT_MMCSD = 2'h2,
        BSSP_BOOT_UART  = 2'h3
    } bssp_boot_t;

    // bank-address-0 pin function encodings
    typedef enum logic [1:0] {
        BSSP_BA0_BANK   = 2'h0,
        BSSP_BA0_ADDR14 = 2'h1,
        BSSP_BA0_GPIO54 = 2'h2,
        BSSP_BA0_RSVD   = 2'h3
    } bssp_ba0_t;

    typedef struct packed {
        logic       width_8bit;
        bssp_ba0_t  ba0_func;
        logic       addr_as_gpio;
    } bssp_pinmux_t;

    // strap field positions within the four config pins
    localparam int BSSP_CFG_WIDTH_BIT = 3;
    localparam int BSSP_CFG_BA0_HI    = 2;
    localparam int BSSP_CFG_BA0_LO    = 1;
    localparam int BSSP_CFG_ADDR_BIT  = 0;

    // APB register map
    localparam logic [7:0]  BSSP_STRAP_OFS  = 8'h00;
    localparam logic [7:0]  BSSP_PINMUX_OFS = 8'h04;
    localparam logic [31:0] BSSP_ZERO       = 32'h0000_0000;
    // pinmux register fields
    localparam int BSSP_PM_ADDR_BIT  = 0;
    localparam int BSSP_PM_BA0_LO    = 1;
    localparam int BSSP_PM_BA0_HI    = 2;
    localparam int BSSP_PM_WIDTH_BIT = 3;
    // strap status register fields
    localparam int BSSP_ST_CFG_LO  = 0;
    localparam int BSSP_ST_CFG_HI  = 3;
    localparam int BSSP_ST_BOOT_LO = 4;
    localparam int BSSP_ST_BOOT_HI = 5;
endpackage

//--- bssp_top.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Operation
// R1: capture two boot straps at reset; 00 NAND, 01 flash, 10 MMC/SD, 11 UART.
// R2: capture four config strap bits at reset; they seed pin-mux defaults.
// R3: config bit 3 default data width: 0 is 16-bit, 1 is 8-bit.
// R4: config bits 2:1 default bank pin: bank0, addr14, gpio54, reserved.
// R5: after sampling, strap pins act as address 13:10 or gpio 67:64.
// R6: config bit 0 default address mux: 0 address bits, 1 gpio.
// R7: straps latched once at reset release, later pin changes ignored.
module bssp_top
    import bssp_pkg::*;
(
    // clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RSTN,
    // strap pins: [5:4] boot select, [3:0] config
    input  wire logic [5:0]         STRAP_IN,
    // address and gpio sources for the four shared pins (13:10 / 67:64)
    input  wire logic [3:0]         ADDR_OUT_IN,
    input  wire logic [3:0]         ADDR_OE_IN,
    input  wire logic [3:0]         GPIO_OUT_IN,
    input  wire logic [3:0]         GPIO_OE_IN,
    // pads
    output logic [3:0]              PAD_OUT,
    output logic [3:0]              PAD_OE,
    output logic [3:0]              GPIO_IN_OUT,
    // decoded settings
    output bssp_boot_t              BOOT_SOURCE,
    output bssp_pinmux_t            PINMUX,
    output logic                    STRAP_DONE,
    // apb slave
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic [31:0]             PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR
);
    import bssp_pkg::*;

    logic       sampled;
    logic [3:0] cfg_strap;
    logic [1:0] boot_strap;
    logic       apb_wr;
    logic       apb_acc;

    assign apb_acc = PSEL && PENABLE && PREADY;
    assign apb_wr  = apb_acc && PWRITE;

    // first clocked edge after release takes the straps, then never again
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sampled    <= 1'b0;
            cfg_strap  <= 4'h0;
            boot_strap <= 2'h0;
        end else if (!sampled) begin
            sampled    <= 1'b1; // R7
            cfg_strap  <= STRAP_IN[3:0]; // R2
            boot_strap <= STRAP_IN[5:4]; // R1
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            STRAP_DONE  <= 1'b0;
            BOOT_SOURCE <= BSSP_BOOT_NAND;
        end else begin
            STRAP_DONE  <= sampled;
            BOOT_SOURCE <= bssp_boot_t'(boot_strap); // R1
        end
    end

    // pin-mux: loaded from straps once, then software may rewrite
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PINMUX <= '0;
        end else if (!sampled) begin
            PINMUX.width_8bit   <= STRAP_IN[BSSP_CFG_WIDTH_BIT]; // R3
            PINMUX.ba0_func     <= bssp_ba0_t'(STRAP_IN[BSSP_CFG_BA0_HI:BSSP_CFG_BA0_LO]); // R4
            PINMUX.addr_as_gpio <= STRAP_IN[BSSP_CFG_ADDR_BIT]; // R6
        end else if (apb_wr && PADDR == BSSP_PINMUX_OFS) begin
            PINMUX.width_8bit   <= PWDATA[BSSP_PM_WIDTH_BIT];
            PINMUX.ba0_func     <= bssp_ba0_t'(PWDATA[BSSP_PM_BA0_HI:BSSP_PM_BA0_LO]);
            PINMUX.addr_as_gpio <= PWDATA[BSSP_PM_ADDR_BIT];
        end
    end

    // pads stay input until sampling ends so straps are not overdriven
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PAD_OUT     <= 4'h0;
            PAD_OE      <= 4'h0;
            GPIO_IN_OUT <= 4'h0;
        end else begin
            GPIO_IN_OUT <= STRAP_IN[3:0];
            if (!sampled) begin
                PAD_OUT <= 4'h0;
                PAD_OE  <= 4'h0;
            end else if (PINMUX.addr_as_gpio) begin
                PAD_OUT <= GPIO_OUT_IN; // R5
                PAD_OE  <= GPIO_OE_IN;
            end else begin
                PAD_OUT <= ADDR_OUT_IN; // R5
                PAD_OE  <= ADDR_OE_IN;
            end
        end
    end

    // apb: zero wait states, unmapped reads zero with error
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA  <= BSSP_ZERO;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA  <= BSSP_ZERO;
            if (PSEL && !PENABLE) begin
                if (PADDR == BSSP_STRAP_OFS) begin
                    PRDATA[BSSP_ST_CFG_HI:BSSP_ST_CFG_LO]   <= cfg_strap;
                    PRDATA[BSSP_ST_BOOT_HI:BSSP_ST_BOOT_LO] <= boot_strap;
                    PSLVERR <= PWRITE;
                end else if (PADDR == BSSP_PINMUX_OFS) begin
                    PRDATA[BSSP_PM_ADDR_BIT] <= PINMUX.addr_as_gpio;
                    PRDATA[BSSP_PM_BA0_HI:BSSP_PM_BA0_LO] <= PINMUX.ba0_func;
                    PRDATA[BSSP_PM_WIDTH_BIT] <= PINMUX.width_8bit;
                end else begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end
endmodule

//--- bssp_strap_model.sv
`timescale 1ns/1ps
module bssp_strap_model (
    // board straps
    input  wire logic [5:0] val,
    output logic      [5:0] pins
);
    assign pins = val;
endmodule

//--- bssp_top_asserts.sv
`timescale 1ns/1ps
module bssp_top_asserts
    import bssp_pkg::*;
(
    // watched ports
    input wire logic         SYS_CLK,
    input wire logic         RSTN,
    input wire logic [5:0]   STRAP_IN,
    input wire logic [3:0]   ADDR_OUT_IN,
    input wire logic [3:0]   GPIO_OUT_IN,
    input wire logic [3:0]   PAD_OUT,
    input wire bssp_boot_t   BOOT_SOURCE,
    input wire bssp_pinmux_t PINMUX,
    input wire logic         STRAP_DONE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    a_boot_capture: assert property ($rose(STRAP_DONE) |->
        BOOT_SOURCE == $past(STRAP_IN[5:4])) else $error("boot");
    a_cfg_capture: assert property ($rose(STRAP_DONE) |->
        PINMUX == $past(STRAP_IN[3:0])) else $error("cfg");
    a_width_dflt: assert property ($rose(STRAP_DONE) |->
        PINMUX.width_8bit == $past(STRAP_IN[3])) else $error("width");
    a_ba0_dflt: assert property ($rose(STRAP_DONE) |->
        PINMUX.ba0_func == $past(STRAP_IN[2:1])) else $error("ba0");
    a_addr_dflt: assert property ($rose(STRAP_DONE) |->
        PINMUX.addr_as_gpio == $past(STRAP_IN[0])) else $error("addr");
    a_pad_addr: assert property (STRAP_DONE && !PINMUX.addr_as_gpio |=>
        PAD_OUT == $past(ADDR_OUT_IN)) else $error("pad addr");
    a_pad_gpio: assert property (STRAP_DONE && PINMUX.addr_as_gpio |=>
        PAD_OUT == $past(GPIO_OUT_IN)) else $error("pad gpio");
    a_boot_hold: assert property (STRAP_DONE [*2] |-> $stable(BOOT_SOURCE))
        else $error("hold");
endmodule
bind bssp_top bssp_top_asserts bssp_top_asserts_i (.SYS_CLK, .RSTN, .STRAP_IN, .ADDR_OUT_IN,
    .GPIO_OUT_IN, .PAD_OUT, .BOOT_SOURCE, .PINMUX, .STRAP_DONE);

//--- bssp_top_test.sv
`timescale 1ns/1ps
module bssp_top_test;
    import bssp_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, prdy, perr, done;
    logic [7:0] padr = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic [5:0] sv = 0, pins;
    logic [3:0] src = 0, pad, poe, gin;
    logic er;
    bssp_boot_t boot;
    bssp_pinmux_t pm;
    int n_mismatch = 0, compares = 0, cyc = 0;
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc > 500) begin n_mismatch++; final_report; end
    bssp_strap_model bssp_strap_model_i (.val(sv), .pins(pins));
    bssp_top bssp_top_i (.SYS_CLK(clk), .RSTN(rstn), .STRAP_IN(pins), .ADDR_OUT_IN(src),
        .ADDR_OE_IN(src), .GPIO_OUT_IN(~src), .GPIO_OE_IN(~src), .PAD_OUT(pad), .PAD_OE(poe),
        .GPIO_IN_OUT(gin), .BOOT_SOURCE(boot), .PINMUX(pm), .STRAP_DONE(done), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk) {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
        @(posedge clk) pen <= 1;
        do @(posedge clk); while (prdy !== 1);
        rd = prd;
        er = perr;
        {psel, pen} <= 2'h0;
    endtask
    task automatic final_report;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 4; i++) begin
            rstn <= 0;
            sv <= {3{i[1:0]}};
            repeat (2) @(posedge clk);
            rstn <= 1;
            repeat (3) @(posedge clk);
            chk("boot", i, boot);
            chk("done", 1, done);
            chk("pinmux", {i[1:0], i[1:0]}, pm);
            sv <= ~sv;
            src <= i[3:0] + 4'h3;
            repeat (3) @(posedge clk);
            chk("held", i, boot);
            chk("pad", i[0] ? 4'(~src) : src, pad);
            chk("pad oe", i[0] ? 4'(~src) : src, poe);
            chk("gpio in", 4'(sv), gin);
            apb(0, BSSP_STRAP_OFS, 0);
            chk("strap reg", {3{i[1:0]}}, rd);
        end
        apb(1, BSSP_PINMUX_OFS, 32'h6);
        apb(0, BSSP_PINMUX_OFS, 0);
        chk("pinmux reg", 32'h6, rd);
        chk("pad addr", src, pad);
        apb(1, BSSP_STRAP_OFS, 0);
        chk("ro err", 1, er);
        apb(0, 8'h08, 0);
        chk("unmapped", 1, er);
        final_report;
    end
endmodule
